/* hw/idd_pkg.sv */
// Purpose: Shared constants, opcodes and lane helpers for the integer DSP datapath
// Assumes: 32-bit operands, one result per accepted operation
// Notes:   Opcode values are local to this block
// Notes on behaviour
// [RL1] Byte reverse word, flags kept
// [RL2] Swap bytes inside each halfword, flags kept
// [RL3] Swap low halfword bytes, sign extend
// [RL4] Rotate through carry; flag form sets N,Z,C
// [RL5] Exchange, add hi, subtract lo, halve
// [RL6] Exchange, subtract hi, add lo, halve
// [RL7] Signed exchanged sub/add, update lane flags
// [RL8] Unsigned exchanged sub/add, update lane flags
// [RL9] Halfword multiply plus accumulator, Q on overflow
// [RL10] Dual products plus accumulator, Q on overflow
// [RL11] 32x32 plus 64-bit accumulator pair
// [RL12] Halfword product into 64-bit pair
// [RL13] Dual products into 64-bit pair
// [RL14] Word by halfword plus accumulator, Q
// [RL15] Product difference plus accumulator, Q
// [RL16] Product difference into 64-bit pair
// [RL17] Accumulator into upper product word
// [RL18] Full 64-bit signed product to pair
// [RL19] Dual products summed, Q on overflow
// [RL20] Rotate, sign extend byte, add
// [RL21] Rotate, extend two bytes, add halfwords
// [RL22] Rotate, sign extend halfword, add
// [RL23] Other flags kept; Q only set
package idd_pkg;

    localparam int unsigned WORD_W   = 32;
    localparam int unsigned HALF_W   = 16;
    localparam int unsigned BYTE_W   = 8;
    localparam int unsigned LANE_W   = HALF_W + 1;
    localparam int unsigned WIDE_W   = 2 * WORD_W;
    localparam int unsigned WH_W     = WORD_W + HALF_W;
    localparam int unsigned LGE_W    = 4;
    localparam int unsigned ROT_W    = 2;
    localparam int unsigned OP_W     = 5;
    localparam int unsigned MSB      = WORD_W - 1;
    localparam int unsigned LGE_LO   = 0;
    localparam int unsigned LGE_HI   = 2;

    localparam logic             FLAG_RST = 1'b0;
    localparam logic [LGE_W-1:0] LGE_RST  = 4'h0;

    typedef enum logic [OP_W-1:0] {
        IDD_OP_NOP     = 5'h00,
        IDD_OP_REVW    = 5'h01,
        IDD_OP_REVH    = 5'h02,
        IDD_OP_REVSX   = 5'h03,
        IDD_OP_RORX    = 5'h04,
        IDD_OP_HADDSUB = 5'h05,
        IDD_OP_HSUBADD = 5'h06,
        IDD_OP_SSUBADD = 5'h07,
        IDD_OP_USUBADD = 5'h08,
        IDD_OP_MACH    = 5'h09,
        IDD_OP_MACD    = 5'h0a,
        IDD_OP_MACL    = 5'h0b,
        IDD_OP_MACLH   = 5'h0c,
        IDD_OP_MACLD   = 5'h0d,
        IDD_OP_MACWH   = 5'h0e,
        IDD_OP_MSUBD   = 5'h0f,
        IDD_OP_MSUBLD  = 5'h10,
        IDD_OP_MACUW   = 5'h11,
        IDD_OP_MULL    = 5'h12,
        IDD_OP_MADDD   = 5'h13,
        IDD_OP_XADDB   = 5'h14,
        IDD_OP_XADDB2  = 5'h15,
        IDD_OP_XADDH   = 5'h16
    } idd_op_e;

    function automatic logic [HALF_W-1:0] hi_half(input logic [WORD_W-1:0] x);
        return x[WORD_W-1:HALF_W];
    endfunction : hi_half

    function automatic logic [HALF_W-1:0] lo_half(input logic [WORD_W-1:0] x);
        return x[HALF_W-1:0];
    endfunction : lo_half

    function automatic logic [BYTE_W-1:0] byte_of(input logic [WORD_W-1:0] x,
                                                  input int unsigned n);
        return x[n*BYTE_W +: BYTE_W];
    endfunction : byte_of

endpackage : idd_pkg

/* hw/idd_datapath.sv */
// Purpose: Execution datapath for reversal, lane arithmetic, DSP multiply and extend-add
// Assumes: Decoder presents one operation per cycle; result one cycle later
// Notes:   Condition, Q and lane flags are held here and shown on outputs
`timescale 1ns/1ps

module idd_datapath #(
    parameter int unsigned DATA_W = idd_pkg::WORD_W
) (
    input  wire logic                       mclk_i,
    input  wire logic                       sys_rst_i,
    input  wire logic                       op_valid_i,
    input  wire logic [idd_pkg::OP_W-1:0]   op_code_i,
    input  wire logic [DATA_W-1:0]          operand_a_i,
    input  wire logic [DATA_W-1:0]          operand_b_i,
    input  wire logic [DATA_W-1:0]          acc_lo_i,
    input  wire logic [DATA_W-1:0]          acc_hi_i,
    input  wire logic                       flag_set_i,
    input  wire logic                       top_a_i,
    input  wire logic                       top_b_i,
    input  wire logic                       exchange_i,
    input  wire logic [idd_pkg::ROT_W-1:0]  rotate_i,
    output logic                            result_valid_o,
    output logic                            result_wide_o,
    output logic [DATA_W-1:0]               result_lo_o,
    output logic [DATA_W-1:0]               result_hi_o,
    output logic                            flag_n_o,
    output logic                            flag_z_o,
    output logic                            flag_c_o,
    output logic                            flag_v_o,
    output logic                            flag_q_o,
    output logic [idd_pkg::LGE_W-1:0]       lane_greater_equal_flags_o
);

    // ==========================================================
    // Elaboration checks
    if (DATA_W != idd_pkg::WORD_W) begin : g_bad_width
        $error("idd_datapath serves 32-bit operands only");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic                       vld;
        logic                       wide;
        logic [DATA_W-1:0]          lo;
        logic [DATA_W-1:0]          hi;
        logic                       n;
        logic                       z;
        logic                       c;
        logic                       v;
        logic                       q;
        logic [idd_pkg::LGE_W-1:0]  lge;
    } idd_state_s;

    localparam idd_state_s STATE_RST = '{
        vld: 1'b0, wide: 1'b0, lo: '0, hi: '0,
        n: idd_pkg::FLAG_RST, z: idd_pkg::FLAG_RST, c: idd_pkg::FLAG_RST,
        v: idd_pkg::FLAG_RST, q: idd_pkg::FLAG_RST, lge: idd_pkg::LGE_RST
    };

    idd_state_s st_q;
    idd_state_s st_d;
    idd_pkg::idd_op_e op;

    assign op = idd_pkg::idd_op_e'(op_code_i);

    // ==========================================================
    // Local lane helpers, so the package is never imported
    function automatic logic [idd_pkg::HALF_W-1:0] hi_half(input logic [DATA_W-1:0] x);
        return idd_pkg::hi_half(x);
    endfunction : hi_half

    function automatic logic [idd_pkg::HALF_W-1:0] lo_half(input logic [DATA_W-1:0] x);
        return idd_pkg::lo_half(x);
    endfunction : lo_half

    function automatic logic [idd_pkg::BYTE_W-1:0] byte_of(input logic [DATA_W-1:0] x,
                                                           input int unsigned n);
        return idd_pkg::byte_of(x, n);
    endfunction : byte_of

    // ==========================================================
    // Operand shaping
    logic [DATA_W-1:0]          b_rot;
    logic [DATA_W-1:0]          b_x;
    logic [idd_pkg::HALF_W-1:0] half_a;
    logic [idd_pkg::HALF_W-1:0] half_b;

    always_comb begin
        unique case (rotate_i)
            2'h0: b_rot = operand_b_i;
            2'h1: b_rot = {byte_of(operand_b_i, 0), operand_b_i[DATA_W-1:idd_pkg::BYTE_W]};
            2'h2: b_rot = {lo_half(operand_b_i), hi_half(operand_b_i)};
            2'h3: b_rot = {operand_b_i[DATA_W-idd_pkg::BYTE_W-1:0], byte_of(operand_b_i, 3)};
        endcase
    end

    assign b_x    = exchange_i ? {lo_half(operand_b_i), hi_half(operand_b_i)} : operand_b_i;
    assign half_a = top_a_i ? hi_half(operand_a_i) : lo_half(operand_a_i);
    assign half_b = top_b_i ? hi_half(operand_b_i) : lo_half(operand_b_i);

    // ==========================================================
    // Halfword lanes, 17 bits so carries and signs survive
    logic signed [idd_pkg::LANE_W-1:0] s_hi_add;
    logic signed [idd_pkg::LANE_W-1:0] s_hi_sub;
    logic signed [idd_pkg::LANE_W-1:0] s_lo_add;
    logic signed [idd_pkg::LANE_W-1:0] s_lo_sub;
    logic        [idd_pkg::LANE_W-1:0] u_lo_add;
    logic        [idd_pkg::LANE_W-1:0] u_hi_sub;

    assign s_hi_add = idd_pkg::LANE_W'($signed(hi_half(operand_a_i)))
                    + idd_pkg::LANE_W'($signed(lo_half(operand_b_i)));
    assign s_hi_sub = idd_pkg::LANE_W'($signed(hi_half(operand_a_i)))
                    - idd_pkg::LANE_W'($signed(lo_half(operand_b_i)));
    assign s_lo_add = idd_pkg::LANE_W'($signed(lo_half(operand_a_i)))
                    + idd_pkg::LANE_W'($signed(hi_half(operand_b_i)));
    assign s_lo_sub = idd_pkg::LANE_W'($signed(lo_half(operand_a_i)))
                    - idd_pkg::LANE_W'($signed(hi_half(operand_b_i)));
    assign u_lo_add = {1'b0, lo_half(operand_a_i)} + {1'b0, hi_half(operand_b_i)};
    assign u_hi_sub = {1'b0, hi_half(operand_a_i)} - {1'b0, lo_half(operand_b_i)};

    // ==========================================================
    // Products, all widened to 64 bits before summing
    logic signed [idd_pkg::WIDE_W-1:0] acc64;
    logic signed [idd_pkg::WIDE_W-1:0] acc32;
    logic signed [idd_pkg::WIDE_W-1:0] p_lo;
    logic signed [idd_pkg::WIDE_W-1:0] p_hi;
    logic signed [idd_pkg::WIDE_W-1:0] p_sel;
    logic signed [idd_pkg::WIDE_W-1:0] p_full;
    logic signed [idd_pkg::WH_W-1:0]   p_wh;
    logic signed [idd_pkg::WIDE_W-1:0] p_wh_top;
    logic signed [idd_pkg::WIDE_W-1:0] sum32;
    logic signed [idd_pkg::WIDE_W-1:0] sum64;
    logic signed [idd_pkg::WIDE_W-1:0] sum_mac_h;
    logic signed [idd_pkg::WIDE_W-1:0] sum_dual;
    logic signed [idd_pkg::WIDE_W-1:0] sum_wh;
    logic signed [idd_pkg::WIDE_W-1:0] sum_dsub;
    logic signed [idd_pkg::WIDE_W-1:0] sum_uw;

    assign acc64  = $signed({acc_hi_i, acc_lo_i});
    assign acc32  = idd_pkg::WIDE_W'($signed(acc_lo_i));
    // Operands widened first so no tool keeps the product at 16 bits
    assign p_lo   = idd_pkg::WIDE_W'($signed(lo_half(operand_a_i)))
                  * idd_pkg::WIDE_W'($signed(lo_half(b_x)));
    assign p_hi   = idd_pkg::WIDE_W'($signed(hi_half(operand_a_i)))
                  * idd_pkg::WIDE_W'($signed(hi_half(b_x)));
    assign p_sel  = idd_pkg::WIDE_W'($signed(half_a))
                  * idd_pkg::WIDE_W'($signed(half_b));
    assign p_full = idd_pkg::WIDE_W'($signed(operand_a_i)) * idd_pkg::WIDE_W'($signed(operand_b_i));
    assign p_wh   = idd_pkg::WH_W'($signed(operand_a_i)) * idd_pkg::WH_W'($signed(half_b));
    // Word-by-half keeps the top 32 bits of the 48-bit product
    assign p_wh_top = idd_pkg::WIDE_W'($signed(p_wh[idd_pkg::WH_W-1:idd_pkg::HALF_W]));

    assign sum_mac_h = p_sel + acc32;
    assign sum_dual  = p_lo + p_hi;
    assign sum_wh    = p_wh_top + acc32;
    assign sum_dsub  = p_lo - p_hi;
    assign sum_uw    = p_full + $signed({acc_lo_i, {DATA_W{1'b0}}});

    // Q is raised when the exact sum does not fit a signed word
    function automatic logic ovf32(input logic signed [idd_pkg::WIDE_W-1:0] w);
        return w != idd_pkg::WIDE_W'($signed(w[idd_pkg::MSB:0]));
    endfunction : ovf32

    always_comb begin
        sum32 = '0;
        sum64 = '0;
        unique case (op)
            idd_pkg::IDD_OP_MACH:   sum32 = sum_mac_h;
            idd_pkg::IDD_OP_MACD:   sum32 = sum_dual + acc32;
            idd_pkg::IDD_OP_MACWH:  sum32 = sum_wh;
            idd_pkg::IDD_OP_MSUBD:  sum32 = sum_dsub + acc32;
            idd_pkg::IDD_OP_MADDD:  sum32 = sum_dual;
            idd_pkg::IDD_OP_MACL:   sum64 = acc64 + p_full;
            idd_pkg::IDD_OP_MACLH:  sum64 = acc64 + p_sel;
            idd_pkg::IDD_OP_MACLD:  sum64 = acc64 + sum_dual;
            idd_pkg::IDD_OP_MSUBLD: sum64 = acc64 + sum_dsub;
            idd_pkg::IDD_OP_MULL:   sum64 = p_full;
            default: begin
                sum32 = '0;
                sum64 = '0;
            end
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        st_d      = st_q;
        st_d.vld  = 1'b0;
        st_d.wide = 1'b0;
        if (op_valid_i) begin
            st_d.vld = 1'b1;
            st_d.hi  = '0;
            unique case (op)
                // [RL1] Reverse four bytes
                idd_pkg::IDD_OP_REVW: st_d.lo = {byte_of(operand_a_i, 0), byte_of(operand_a_i, 1),
                                                 byte_of(operand_a_i, 2), byte_of(operand_a_i, 3)};
                // [RL2] Swap within halfwords
                idd_pkg::IDD_OP_REVH: st_d.lo = {byte_of(operand_a_i, 2), byte_of(operand_a_i, 3),
                                                 byte_of(operand_a_i, 0), byte_of(operand_a_i, 1)};
                // [RL3] Swap then sign extend
                idd_pkg::IDD_OP_REVSX: st_d.lo = DATA_W'($signed({byte_of(operand_a_i, 0),
                                                                  byte_of(operand_a_i, 1)}));
                // [RL4] Carry enters at the top
                idd_pkg::IDD_OP_RORX: begin
                    st_d.lo = {st_q.c, operand_a_i[DATA_W-1:1]};
                    if (flag_set_i) begin
                        st_d.n = st_q.c;
                        st_d.z = ({st_q.c, operand_a_i[DATA_W-1:1]} == '0);
                        st_d.c = operand_a_i[0];
                    end
                end
                // [RL5] Halved add high, subtract low
                idd_pkg::IDD_OP_HADDSUB: st_d.lo = {s_hi_add[idd_pkg::HALF_W:1],
                                                  s_lo_sub[idd_pkg::HALF_W:1]};
                // [RL6] Halved subtract high, add low
                idd_pkg::IDD_OP_HSUBADD: st_d.lo = {s_hi_sub[idd_pkg::HALF_W:1],
                                                  s_lo_add[idd_pkg::HALF_W:1]};
                // [RL7] Signed lanes set lane flags
                idd_pkg::IDD_OP_SSUBADD: begin
                    st_d.lo = {s_hi_sub[idd_pkg::HALF_W-1:0], s_lo_add[idd_pkg::HALF_W-1:0]};
                    st_d.lge = {{2{~s_hi_sub[idd_pkg::HALF_W]}}, {2{~s_lo_add[idd_pkg::HALF_W]}}};
                end
                // [RL8] Unsigned lanes set lane flags
                idd_pkg::IDD_OP_USUBADD: begin
                    st_d.lo = {u_hi_sub[idd_pkg::HALF_W-1:0], u_lo_add[idd_pkg::HALF_W-1:0]};
                    st_d.lge = {{2{~u_hi_sub[idd_pkg::HALF_W]}}, {2{u_lo_add[idd_pkg::HALF_W]}}};
                end
                // [RL9] [RL10] [RL14] [RL15] [RL19] Word results, sticky Q
                idd_pkg::IDD_OP_MACH, idd_pkg::IDD_OP_MACD, idd_pkg::IDD_OP_MACWH,
                idd_pkg::IDD_OP_MSUBD, idd_pkg::IDD_OP_MADDD: begin
                    st_d.lo = sum32[idd_pkg::MSB:0];
                    // [RL23] Q only ever rises
                    st_d.q  = st_q.q | ovf32(sum32);
                end
                // [RL11] [RL12] [RL13] [RL16] [RL18] Pair results, flags kept
                idd_pkg::IDD_OP_MACL, idd_pkg::IDD_OP_MACLH, idd_pkg::IDD_OP_MACLD,
                idd_pkg::IDD_OP_MSUBLD, idd_pkg::IDD_OP_MULL: begin
                    st_d.wide = 1'b1;
                    st_d.lo   = sum64[idd_pkg::MSB:0];
                    st_d.hi   = sum64[idd_pkg::WIDE_W-1:DATA_W];
                end
                // [RL17] Upper word only
                idd_pkg::IDD_OP_MACUW: st_d.lo = sum_uw[idd_pkg::WIDE_W-1:DATA_W];
                // [RL20] Byte extend add
                idd_pkg::IDD_OP_XADDB: st_d.lo = operand_a_i
                                               + DATA_W'($signed(byte_of(b_rot, 0)));
                // [RL21] Two bytes into halfword lanes
                idd_pkg::IDD_OP_XADDB2: st_d.lo = {
                    hi_half(operand_a_i) + idd_pkg::HALF_W'($signed(byte_of(b_rot, 2))),
                    lo_half(operand_a_i) + idd_pkg::HALF_W'($signed(byte_of(b_rot, 0)))};
                // [RL22] Halfword extend add
                idd_pkg::IDD_OP_XADDH: st_d.lo = operand_a_i
                                               + DATA_W'($signed(lo_half(b_rot)));
                idd_pkg::IDD_OP_NOP: st_d.lo = '0;
                // Unknown code: answer zero, touch no flag
                default: st_d.lo = '0;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs
    assign result_valid_o             = st_q.vld;
    assign result_wide_o              = st_q.wide;
    assign result_lo_o                = st_q.lo;
    assign result_hi_o                = st_q.hi;
    assign flag_n_o                   = st_q.n;
    assign flag_z_o                   = st_q.z;
    assign flag_c_o                   = st_q.c;
    assign flag_v_o                   = st_q.v;
    assign flag_q_o                   = st_q.q;
    assign lane_greater_equal_flags_o = st_q.lge;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    logic       past_go;
    assign past_go = op_valid_i;

    a_byte_swap_word: assert property (past_go && op == idd_pkg::IDD_OP_REVW |=> // [RL1]
        result_lo_o == {$past(operand_a_i[7:0]), $past(operand_a_i[15:8]),
                        $past(operand_a_i[23:16]), $past(operand_a_i[31:24])}
        && $stable(flag_c_o) && $stable(flag_q_o))
        else $error("byte reverse word wrong");

    a_byte_swap_half: assert property (past_go && op == idd_pkg::IDD_OP_REVH |=> // [RL2]
        result_lo_o == {$past(operand_a_i[23:16]), $past(operand_a_i[31:24]),
                        $past(operand_a_i[7:0]), $past(operand_a_i[15:8])})
        else $error("byte reverse halfwords wrong");

    a_swap_sign_ext: assert property (past_go && op == idd_pkg::IDD_OP_REVSX |=> // [RL3]
        result_lo_o[31:16] == {16{$past(operand_a_i[7])}}
        && result_lo_o[15:0] == {$past(operand_a_i[7:0]), $past(operand_a_i[15:8])})
        else $error("reverse low half sign extend wrong");

    a_rotx_flags: assert property (past_go && op == idd_pkg::IDD_OP_RORX && flag_set_i |=> // [RL4]
        flag_c_o == $past(operand_a_i[0]) && flag_n_o == $past(flag_c_o)
        && result_lo_o[31] == $past(flag_c_o) && flag_z_o == (result_lo_o == '0))
        else $error("rotate extended flags wrong");

    a_signed_lane_flag: assert property (past_go && op == idd_pkg::IDD_OP_SSUBADD |=> // [RL7]
        lane_greater_equal_flags_o[3] == !$past(s_hi_sub[idd_pkg::HALF_W]))
        else $error("signed lane flag wrong");

    a_q_sticky: assert property ($past(flag_q_o) |-> flag_q_o) // [RL23]
        else $error("Q flag cleared");

    a_lane_flag_hold: assert property (past_go && op != idd_pkg::IDD_OP_SSUBADD // [RL23]
        && op != idd_pkg::IDD_OP_USUBADD |=> $stable(lane_greater_equal_flags_o))
        else $error("lane flags changed by other op");

    a_mull_pair: assert property (past_go && op == idd_pkg::IDD_OP_MULL |=> // [RL18]
        result_wide_o && {result_hi_o, result_lo_o} ==
        64'($signed($past(operand_a_i))) * 64'($signed($past(operand_b_i))))
        else $error("long multiply wrong");

    a_xaddb_sum: assert property (past_go && op == idd_pkg::IDD_OP_XADDB // [RL20]
        && rotate_i == 2'h0 |=> result_lo_o ==
        $past(operand_a_i) + 32'($signed($past(operand_b_i[7:0]))))
        else $error("byte extend add wrong");

    a_result_next: assert property (past_go |=> result_valid_o ##1 !result_valid_o || $past(op_valid_i))
        else $error("result valid timing wrong");

    c_q_rise:   cover property (past_go && op == idd_pkg::IDD_OP_MACD ##1 $rose(flag_q_o));
    c_long_mac: cover property (past_go && op == idd_pkg::IDD_OP_MACL ##1 result_wide_o);
    c_usub_all: cover property (past_go && op == idd_pkg::IDD_OP_USUBADD ##1
                                lane_greater_equal_flags_o == 4'hf);
    c_rotx_set: cover property (past_go && op == idd_pkg::IDD_OP_RORX && flag_set_i);

endmodule : idd_datapath

/* tb/idd_dec_model.sv */
// Purpose: Decoder and register file stand-in that feeds the datapath
// Assumes: One operation per cycle, launched just after a falling edge
// Notes:   Idle operands flip on each idle issue so a stale value can never pass
`timescale 1ns/1ps

module idd_dec_model (
    output logic                           op_valid_o,
    output logic [idd_pkg::OP_W-1:0]       op_code_o,
    output logic [31:0]                    operand_a_o,
    output logic [31:0]                    operand_b_o,
    output logic [31:0]                    acc_lo_o,
    output logic [31:0]                    acc_hi_o,
    output logic                           flag_set_o,
    output logic                           top_a_o,
    output logic                           top_b_o,
    output logic                           exchange_o,
    output logic [idd_pkg::ROT_W-1:0]      rotate_o
);
    initial begin
        issue(1'b0, 5'h00, 32'h0, 32'h0, 32'h0, 32'h0, 6'h00);
    end

    task automatic issue(input logic v, input logic [4:0] op, input logic [31:0] a, b, al, ah,
                         input logic [5:0] m);
        op_valid_o = v;
        op_code_o = op;
        {flag_set_o, top_a_o, top_b_o, exchange_o, rotate_o} = m;
        if (v) begin
            {operand_a_o, operand_b_o, acc_lo_o, acc_hi_o} = {a, b, al, ah};
        end else begin
            {operand_a_o, operand_b_o, acc_lo_o, acc_hi_o} =
                ~{operand_a_o, operand_b_o, acc_lo_o, acc_hi_o};
        end
    endtask : issue
endmodule : idd_dec_model

/* tb/tb_top.sv */
// Purpose: Self-checking bench comparing the datapath with a behavioural model
// Assumes: Result and flags are visible one cycle after the operation is taken
// Notes:   Corner operands are mixed in so overflow and sign paths get exercised
`timescale 1ns/1ps

module tb_top;
    logic mclk_i, sys_rst_i, op_valid, flag_set, top_a, top_b, exchange;
    logic [4:0] op_code;
    logic [1:0] rotate;
    logic [31:0] opa, opb, acc_lo, acc_hi, res_lo, res_hi;
    logic res_valid, res_wide, fn, fz, fc, fv, fq;
    logic [3:0] lge;
    logic n_m, z_m, c_m, q_m, w_m;
    logic [3:0] lge_m;
    logic [63:0] r_m;
    int bad_count, compares, cycles;
    logic [31:0] corner [4] = '{32'h80008000, 32'h7fff7fff, 32'hffffffff, 32'h0};

    idd_dec_model idd_dec_model_i (.op_valid_o(op_valid), .op_code_o(op_code), .operand_a_o(opa),
        .operand_b_o(opb), .acc_lo_o(acc_lo), .acc_hi_o(acc_hi), .flag_set_o(flag_set),
        .top_a_o(top_a), .top_b_o(top_b), .exchange_o(exchange), .rotate_o(rotate));
    idd_datapath idd_datapath_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .op_valid_i(op_valid),
        .op_code_i(op_code), .operand_a_i(opa), .operand_b_i(opb), .acc_lo_i(acc_lo),
        .acc_hi_i(acc_hi), .flag_set_i(flag_set), .top_a_i(top_a), .top_b_i(top_b),
        .exchange_i(exchange), .rotate_i(rotate), .result_valid_o(res_valid),
        .result_wide_o(res_wide), .result_lo_o(res_lo), .result_hi_o(res_hi), .flag_n_o(fn),
        .flag_z_o(fz), .flag_c_o(fc), .flag_v_o(fv), .flag_q_o(fq),
        .lane_greater_equal_flags_o(lge));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // ========================================
    // Reference model
    task automatic predict(input int op, input logic [31:0] a, b, al, ah, input logic [5:0] m);
        logic [31:0] bx, rb;
        logic signed [15:0] ha, hb;
        longint p1, p2, s, h, l, acc;
        int k;
        // 1: word with sticky Q on overflow, 2: register pair, 3: plain word
        k = (op inside {9, 10, 14, 15, 19}) ? 1 :
            (op inside {11, 12, 13, 16, 18}) ? 2 :
            (op inside {20, 22}) ? 3 : 0;
        w_m = 1'b0;
        r_m = 64'h0;
        bx = m[2] ? {b[15:0], b[31:16]} : b;
        rb = (b >> (8 * m[1:0])) | (b << (32 - 8 * m[1:0]));
        ha = m[4] ? a[31:16] : a[15:0];
        hb = m[3] ? b[31:16] : b[15:0];
        p1 = $signed(a[15:0]) * $signed(bx[15:0]);
        p2 = $signed(a[31:16]) * $signed(bx[31:16]);
        acc = $signed({ah, al});
        case (op)
            1: r_m = {a[7:0], a[15:8], a[23:16], a[31:24]};
            2: r_m = {a[23:16], a[31:24], a[7:0], a[15:8]};
            3: r_m = {{16{a[7]}}, a[7:0], a[15:8]};
            4: begin
                r_m = {c_m, a[31:1]};
                if (m[5]) {n_m, z_m, c_m} = {r_m[31], r_m == 64'h0, a[0]};
            end
            5, 6, 7: begin
                h = (op == 5) ? $signed(a[31:16]) + $signed(b[15:0]) : $signed(a[31:16]) - $signed(b[15:0]);
                l = (op == 5) ? $signed(a[15:0]) - $signed(b[31:16]) : $signed(a[15:0]) + $signed(b[31:16]);
                r_m = (op == 7) ? {h[15:0], l[15:0]} : {h[16:1], l[16:1]};
                if (op == 7) lge_m = {{2{h >= 0}}, {2{l >= 0}}};
            end
            8: begin
                h = a[31:16] - b[15:0];
                l = a[15:0] + b[31:16];
                r_m = {h[15:0], l[15:0]};
                lge_m = {{2{h >= 0}}, {2{l > 65535}}};
            end
            9: s = ha * hb + $signed(al);
            10: s = p1 + p2 + $signed(al);
            11: s = $signed(a) * $signed(b) + acc;
            12: s = ha * hb + acc;
            13: s = p1 + p2 + acc;
            14: s = (($signed(a) * hb) >>> 16) + $signed(al);
            15: s = p1 - p2 + $signed(al);
            16: s = p1 - p2 + acc;
            17: begin
                s = $signed(a) * $signed(b);
                r_m = 32'(s[63:32] + al);
            end
            18: s = $signed(a) * $signed(b);
            19: s = p1 + p2;
            20: s = $signed(a) + $signed(rb[7:0]);
            21: r_m = {a[31:16] + {{8{rb[23]}}, rb[23:16]}, a[15:0] + {{8{rb[7]}}, rb[7:0]}};
            22: s = $signed(a) + $signed(rb[15:0]);
            default: r_m = 64'h0;
        endcase
        if (k == 1 && s != longint'($signed(s[31:0]))) q_m = 1'b1;
        if (k > 0) r_m = (k == 2) ? s : {32'h0, s[31:0]};
        w_m = (k == 2);
    endtask : predict

    // ========================================
    // Checking and stimulus
    task automatic check(input string nm, input logic [79:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    function automatic logic [79:0] seen_all();
        return {res_valid, res_wide, fn, fz, fc, fv, fq, lge, res_hi, res_lo};
    endfunction : seen_all

    task automatic run_op(input int op, input logic [31:0] a, b, al, ah, input logic [5:0] m);
        // Single source forms get the same word on both operands
        if (op inside {[1:4]}) b = a;
        idd_dec_model_i.issue(1'b1, op[4:0], a, b, al, ah, m);
        predict(op, a, b, al, ah, m);
        @(negedge mclk_i);
        check($sformatf("op %0d", op), seen_all(),
              {1'b1, w_m, n_m, z_m, c_m, 1'b0, q_m, lge_m, r_m});
    endtask : run_op

    function automatic logic [31:0] rnd();
        return ($urandom_range(3) == 0) ? corner[$urandom_range(3)] : $urandom;
    endfunction : rnd

    task automatic close_out();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        sys_rst_i = 1'b1;
        {n_m, z_m, c_m, q_m, lge_m} = 8'h00;
        void'($urandom(20987));
        repeat (20) @(posedge mclk_i);
        @(negedge mclk_i);
        sys_rst_i = 1'b0;
        for (int it = 0; it < 6; it++)
            for (int op = 0; op < 32; op++) run_op(op, rnd(), rnd(), rnd(), rnd(), 6'($urandom));
        $display("test all codes done");
        idd_dec_model_i.issue(1'b0, 5'h00, 32'h0, 32'h0, 32'h0, 32'h0, 6'h00);
        @(negedge mclk_i);
        check("idle valid", {79'h0, res_valid}, 80'h0);
        $display("test idle gap done");
        sys_rst_i = 1'b1;
        @(negedge mclk_i);
        check("reset outputs", seen_all(), 80'h0);
        {n_m, z_m, c_m, q_m, lge_m} = 8'h00;
        sys_rst_i = 1'b0;
        $display("test mid reset done");
        // Only overflowing sum of two largest products, then a calm MAC
        run_op(19, 32'h80008000, 32'h80008000, 32'h0, 32'h0, 6'h00);
        run_op(9, 32'h00020003, 32'h00040005, 32'h10, 32'h0, 6'h00);
        run_op(4, 32'h00000001, 32'h0, 32'h0, 32'h0, 6'h20);
        run_op(4, 32'h00000000, 32'h0, 32'h0, 32'h0, 6'h20);
        $display("test sticky and carry done");
        close_out();
    end
endmodule : tb_top
